// ===== core/cmd_link_pkg.sv
// Constants, field layout and state type of the serial command link
package cmd_link_pkg;
  // Core clock rate and documented link timings
  localparam int CLK_MHZ = 40;
  localparam int DEB_NS = 70;
  localparam int SHUT_NS = 1200;
  // Least times round up to whole cycles
  localparam int DEB_CYC = (DEB_NS * CLK_MHZ + 999) / 1000;
  localparam int SHUT_CYC = (SHUT_NS * CLK_MHZ + 999) / 1000;
  localparam int DEB_CW = 2;
  localparam int SHUT_CW = 6;
  localparam logic [DEB_CW-1:0] DEB_LIMIT = DEB_CW'(DEB_CYC);
  localparam logic [SHUT_CW-1:0] SHUT_LIMIT = SHUT_CW'(SHUT_CYC - 1);
  // Command byte layout, sent msb first
  localparam int CMD_W = 8;
  localparam int BIT_MODE = 7;
  localparam int PROTO_HI = 6;
  localparam int PROTO_LO = 4;
  localparam int BIT_DEPTH = 3;
  localparam int BIT_AM = 2;
  localparam int BIT_BAUD = 1;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] PROTO_DIRECT = 3'h0;
  localparam logic [2:0] PROTO_RES_A = 3'h5;
  localparam logic [2:0] PROTO_RES_B = 3'h6;
  localparam logic [2:0] PROTO_CFG = 3'h7;
  localparam logic [7:0] CFG_READ = 8'h71;
  localparam logic [7:0] CFG_WRITE = 8'h7D;
  localparam logic [7:0] CFG_PDOWN = 8'h7E;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_CMD = 3'h2,
    ST_PAYLOAD = 3'h3,
    ST_DIR_WAIT = 3'h4,
    ST_DIR_ARM = 3'h5,
    ST_DIR_RUN = 3'h6
  } link_state_type;
endpackage

// ===== core/line_events_if.sv
// Filtered levels and edges of the strobe and data-in lines
`timescale 1ns/1ps
interface line_events_if;
  logic strobe;
  logic data;
  logic strobe_rise;
  logic strobe_fall;
  logic data_rise;
  logic data_fall;
  modport src (output strobe, output data, output strobe_rise, output strobe_fall,
               output data_rise, output data_fall);
  modport snk (input strobe, input data, input strobe_rise, input strobe_fall,
               input data_rise, input data_fall);
endinterface

// ===== core/line_filter.sv
// Resynchroniser and debouncer for the two link input lines
`timescale 1ns/1ps
module line_filter (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic strobe_in,
  input wire logic data_in,
  line_events_if.src ev
);
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] level_ff;
  logic [1:0] prev_ff;
  logic [cmd_link_pkg::DEB_CW-1:0] cnt_ff [2];

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end else begin
      sync1_ff <= {strobe_in, data_in};
      sync2_ff <= sync1_ff;
    end
  end

  // A new level is taken only once it has held for the whole debounce time
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      level_ff <= 2'h0;
      prev_ff <= 2'h0;
      cnt_ff[0] <= '0;
      cnt_ff[1] <= '0;
    end else begin
      prev_ff <= level_ff;
      for (int i = 0; i < 2; i++) begin
        if (sync2_ff[i] == level_ff[i]) begin
          cnt_ff[i] <= '0;
        end else if (cnt_ff[i] == cmd_link_pkg::DEB_LIMIT) begin
          level_ff[i] <= sync2_ff[i];
          cnt_ff[i] <= '0;
        end else begin
          cnt_ff[i] <= cnt_ff[i] + 1'b1;
        end
      end
    end
  end

  assign ev.strobe = level_ff[1];
  assign ev.data = level_ff[0];
  assign ev.strobe_rise = level_ff[1] & ~prev_ff[1];
  assign ev.strobe_fall = ~level_ff[1] & prev_ff[1];
  assign ev.data_rise = level_ff[0] & ~prev_ff[0];
  assign ev.data_fall = ~level_ff[0] & prev_ff[0];

  AST_DEB_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (level_ff[0] != $past(level_ff[0])) |-> ($past(sync2_ff[0], 4) == level_ff[0]))
    else $error("data level changed before the debounce time");
endmodule // line_filter

// ===== core/cmd_check.sv
// Parity check and class decode of an assembled command byte
`timescale 1ns/1ps
module cmd_check (
  input wire logic [7:0] byte_in,
  output logic parity_ok_out,
  output logic direct_out,
  output logic reserved_out,
  output logic config_out,
  output logic cfg_read_out,
  output logic cfg_write_out,
  output logic cfg_pdown_out
);
  logic [2:0] proto;

  assign proto = byte_in[cmd_link_pkg::PROTO_HI:cmd_link_pkg::PROTO_LO];
  assign parity_ok_out = ~(^byte_in);
  assign direct_out = proto == cmd_link_pkg::PROTO_DIRECT;
  assign reserved_out = (proto == cmd_link_pkg::PROTO_RES_A) | (proto == cmd_link_pkg::PROTO_RES_B);
  assign config_out = proto == cmd_link_pkg::PROTO_CFG;
  assign cfg_read_out = byte_in == cmd_link_pkg::CFG_READ;
  assign cfg_write_out = byte_in == cmd_link_pkg::CFG_WRITE;
  assign cfg_pdown_out = byte_in == cmd_link_pkg::CFG_PDOWN;
endmodule // cmd_check

// ===== core/transceiver_command_link.sv
// Three-wire serial command front end: framing, command decode, transmitter control
`timescale 1ns/1ps
// What this block does
// - Strobe and data-in are resynchronised and debounced; changes shorter than 70 ns are ignored.
// - Transaction is start, command byte msb first, payload bits, stop.
// - Any start condition outside direct run begins a new sequence, whatever came before.
// - Start is data-in rising while strobe stays high.
// - Stop is data-in falling while strobe stays high; it ends the payload.
// - Each bit is captured on the strobe rising edge.
// - Bits 6 to 4 select protocol, direct mode or configuration commands.
// - Bit 3 modulation depth, bit 2 AM or FSK, bit 1 baud rate.
// - Bit 0 makes the command byte even parity.
// - Configuration bytes decode to register read, register write and power down.
// - Start then stop inside one strobe high period switches the transmitter off.
// - That data pulse must last 1.2 us to count as a shutdown.
// - Transmitter stays on after an RF command until a shutdown or a direct-mode exit.
// - New commands are taken while the transmitter is still on.
// - RF commands switch the transmitter on; configuration commands leave it alone.
// - Start, single one bit, stop switches the transmitter on.
// - Register mode command is one leading one bit using stored configuration.
// - Direct mode routes data-in to modulator, demod to data-out; strobe fall exits.
module transceiver_command_link (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic strobe_in,
  input wire logic data_in,
  input wire logic demod_in,
  output logic data_out,
  output logic tx_on_out,
  output logic mod_out,
  output logic direct_active_out,
  output logic register_mode_out,
  output logic [2:0] protocol_out,
  output logic depth_full_out,
  output logic am_demod_out,
  output logic high_baud_out,
  output logic cmd_valid_out,
  output logic parity_err_out,
  output logic cfg_read_out,
  output logic cfg_write_out,
  output logic power_down_out,
  output logic cfg_load_out,
  output logic payload_valid_out,
  output logic payload_bit_out,
  output logic frame_end_out,
  output logic carrier_shutdown_out
);
  line_events_if ev ();

  cmd_link_pkg::link_state_type state_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] shift_ff;
  logic [cmd_link_pkg::SHUT_CW-1:0] pulse_cnt_ff;
  logic [1:0] demod_sync_ff;
  logic tx_on_ff;
  logic mod_ff;
  logic dout_ff;
  logic reg_mode_ff;
  logic [2:0] proto_ff;
  logic depth_ff;
  logic am_ff;
  logic baud_ff;
  logic cmd_valid_ff;
  logic parity_err_ff;
  logic cfg_read_ff;
  logic cfg_write_ff;
  logic pdown_ff;
  logic cfg_load_ff;
  logic pay_valid_ff;
  logic pay_bit_ff;
  logic frame_end_ff;
  logic shut_ff;

  logic in_run;
  logic start_ev;
  logic stop_ev;
  logic bit_ev;
  logic reg_hit;
  logic byte_done;
  logic rf_ok;
  logic shutdown;
  logic run_exit;
  logic [7:0] cmd_byte;
  logic par_ok;
  logic is_direct;
  logic is_res;
  logic is_cfg;
  logic c_rd;
  logic c_wr;
  logic c_pd;

  line_filter u_filter (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .strobe_in(strobe_in),
    .data_in(data_in),
    .ev(ev.src)
  );

  cmd_check u_check (
    .byte_in(cmd_byte),
    .parity_ok_out(par_ok),
    .direct_out(is_direct),
    .reserved_out(is_res),
    .config_out(is_cfg),
    .cfg_read_out(c_rd),
    .cfg_write_out(c_wr),
    .cfg_pdown_out(c_pd)
  );

  // In direct run data-in is modulation, so its edges are not framing
  assign in_run = state_ff == cmd_link_pkg::ST_DIR_RUN;
  assign start_ev = ev.data_rise & ev.strobe & ~in_run;
  assign stop_ev = ev.data_fall & ev.strobe & ~in_run;
  assign bit_ev = ev.strobe_rise;
  assign cmd_byte = {shift_ff, ev.data};
  assign reg_hit = (state_ff == cmd_link_pkg::ST_CMD) & bit_ev
                   & (bit_cnt_ff == 3'h0) & ev.data;
  assign byte_done = (state_ff == cmd_link_pkg::ST_CMD) & bit_ev
                     & (bit_cnt_ff == cmd_link_pkg::LAST_BIT);
  assign rf_ok = byte_done & par_ok & ~is_cfg & ~is_res;
  // A start that closes within the same strobe high is a shutdown only if long enough
  assign shutdown = stop_ev & (state_ff == cmd_link_pkg::ST_START)
                    & (pulse_cnt_ff == cmd_link_pkg::SHUT_LIMIT);
  assign run_exit = in_run & ev.strobe_fall;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_ff <= cmd_link_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_ff <= cmd_link_pkg::ST_START;
    end else if (stop_ev) begin
      if (state_ff == cmd_link_pkg::ST_DIR_WAIT) begin
        state_ff <= cmd_link_pkg::ST_DIR_ARM;
      end else begin
        state_ff <= cmd_link_pkg::ST_IDLE;
      end
    end else begin
      unique case (state_ff)
        cmd_link_pkg::ST_IDLE: begin
          state_ff <= cmd_link_pkg::ST_IDLE;
        end
        cmd_link_pkg::ST_START: begin
          if (ev.strobe_fall) begin
            state_ff <= cmd_link_pkg::ST_CMD;
          end
        end
        cmd_link_pkg::ST_CMD: begin
          if (reg_hit) begin
            state_ff <= cmd_link_pkg::ST_PAYLOAD;
          end else if (byte_done) begin
            if (!par_ok || is_res) begin
              state_ff <= cmd_link_pkg::ST_IDLE;
            end else if (is_direct) begin
              state_ff <= cmd_link_pkg::ST_DIR_WAIT;
            end else if (!is_cfg || c_wr) begin
              state_ff <= cmd_link_pkg::ST_PAYLOAD;
            end else begin
              state_ff <= cmd_link_pkg::ST_IDLE;
            end
          end
        end
        cmd_link_pkg::ST_PAYLOAD: begin
          state_ff <= cmd_link_pkg::ST_PAYLOAD;
        end
        cmd_link_pkg::ST_DIR_WAIT: begin
          state_ff <= cmd_link_pkg::ST_DIR_WAIT;
        end
        cmd_link_pkg::ST_DIR_ARM: begin
          if (bit_ev) begin
            state_ff <= cmd_link_pkg::ST_DIR_RUN;
          end
        end
        cmd_link_pkg::ST_DIR_RUN: begin
          if (ev.strobe_fall) begin
            state_ff <= cmd_link_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= cmd_link_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Command bits shift in msb first
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bit_cnt_ff <= 3'h0;
      shift_ff <= 7'h00;
    end else if (start_ev) begin
      bit_cnt_ff <= 3'h0;
    end else if ((state_ff == cmd_link_pkg::ST_CMD) && bit_ev) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      shift_ff <= cmd_byte[6:0];
    end
  end

  // Saturating width of the data pulse that opened the sequence
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pulse_cnt_ff <= '0;
    end else if (start_ev) begin
      pulse_cnt_ff <= '0;
    end else if ((state_ff == cmd_link_pkg::ST_START) && (pulse_cnt_ff != cmd_link_pkg::SHUT_LIMIT)) begin
      pulse_cnt_ff <= pulse_cnt_ff + 1'b1;
    end
  end

  // Transmitter stays on until a shutdown or a direct-mode exit
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_on_ff <= 1'b0;
    end else if (shutdown || run_exit) begin
      tx_on_ff <= 1'b0;
    end else if (reg_hit || rf_ok) begin
      tx_on_ff <= 1'b1;
    end
  end

  // Configuration held for the modulator, demodulator and encoder
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_mode_ff <= 1'b0;
      proto_ff <= 3'h0;
      depth_ff <= 1'b0;
      am_ff <= 1'b0;
      baud_ff <= 1'b0;
    end else if (reg_hit) begin
      reg_mode_ff <= 1'b1;
    end else if (rf_ok) begin
      reg_mode_ff <= cmd_byte[cmd_link_pkg::BIT_MODE];
      proto_ff <= cmd_byte[cmd_link_pkg::PROTO_HI:cmd_link_pkg::PROTO_LO];
      depth_ff <= cmd_byte[cmd_link_pkg::BIT_DEPTH];
      am_ff <= cmd_byte[cmd_link_pkg::BIT_AM];
      baud_ff <= cmd_byte[cmd_link_pkg::BIT_BAUD];
    end
  end

  // One-cycle command and payload strobes, and the payload bit held from one strobe rise to the next
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cmd_valid_ff <= 1'b0;
      parity_err_ff <= 1'b0;
      cfg_read_ff <= 1'b0;
      cfg_write_ff <= 1'b0;
      pdown_ff <= 1'b0;
      pay_valid_ff <= 1'b0;
      pay_bit_ff <= 1'b0;
      frame_end_ff <= 1'b0;
      shut_ff <= 1'b0;
    end else begin
      cmd_valid_ff <= reg_hit | rf_ok;
      parity_err_ff <= byte_done & ~par_ok;
      cfg_read_ff <= byte_done & par_ok & c_rd;
      cfg_write_ff <= byte_done & par_ok & c_wr;
      pdown_ff <= byte_done & par_ok & c_pd;
      pay_valid_ff <= (state_ff == cmd_link_pkg::ST_PAYLOAD) & bit_ev;
      pay_bit_ff <= bit_ev ? ev.data : pay_bit_ff;
      frame_end_ff <= stop_ev & (state_ff == cmd_link_pkg::ST_PAYLOAD);
      shut_ff <= shutdown;
    end
  end

  // Payload bits belong to the configuration register until the next start
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || start_ev) begin
      cfg_load_ff <= 1'b0;
    end else if (byte_done && par_ok && c_wr) begin
      cfg_load_ff <= 1'b1;
    end
  end

  // Direct path; the demodulator output is asynchronous to this clock
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      demod_sync_ff <= 2'h0;
      mod_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      demod_sync_ff <= {demod_sync_ff[0], demod_in};
      mod_ff <= in_run & ~ev.strobe_fall & ev.data;
      dout_ff <= in_run & ~ev.strobe_fall & demod_sync_ff[1];
    end
  end

  assign data_out = dout_ff;
  assign tx_on_out = tx_on_ff;
  assign mod_out = mod_ff;
  assign direct_active_out = in_run;
  assign register_mode_out = reg_mode_ff;
  assign protocol_out = proto_ff;
  assign depth_full_out = depth_ff;
  assign am_demod_out = am_ff;
  assign high_baud_out = baud_ff;
  assign cmd_valid_out = cmd_valid_ff;
  assign parity_err_out = parity_err_ff;
  assign cfg_read_out = cfg_read_ff;
  assign cfg_write_out = cfg_write_ff;
  assign power_down_out = pdown_ff;
  assign cfg_load_out = cfg_load_ff;
  assign payload_valid_out = pay_valid_ff;
  assign payload_bit_out = pay_bit_ff;
  assign frame_end_out = frame_end_ff;
  assign carrier_shutdown_out = shut_ff;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // Checker-only count of cycles since a start with data and strobe both still high.
  // It is kept apart from the shutdown counter so that a fault there cannot hide itself.
  logic [cmd_link_pkg::SHUT_CW-1:0] hi_len_ff;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hi_len_ff <= '0;
    end else if (!(ev.data && ev.strobe)) begin
      hi_len_ff <= '0;
    end else if (start_ev || ((hi_len_ff != '0) && (hi_len_ff != '1))) begin
      hi_len_ff <= hi_len_ff + 1'b1;
    end
  end

  sequence seq_pulse_end;
    ev.data_fall && ev.strobe;
  endsequence

  sequence seq_long_pulse;
    (hi_len_ff >= cmd_link_pkg::SHUT_CYC) ##0 seq_pulse_end;
  endsequence

  AST_SHUTDOWN_OFF: assert property (seq_long_pulse |=> !tx_on_ff && shut_ff)
    else $error("long pulse under high strobe did not stop the transmitter");
  AST_SHORT_SPIKE: assert property (start_ev ##[1:8] (ev.data_fall && ev.strobe) |=> $stable(tx_on_ff))
    else $error("short data spike changed the transmitter state");
  AST_START_NEW: assert property (start_ev |=> state_ff == cmd_link_pkg::ST_START)
    else $error("start condition did not open a new sequence");
  AST_REG_ON: assert property (reg_hit |=> tx_on_ff && reg_mode_ff && cmd_valid_ff)
    else $error("register mode bit did not switch the transmitter on");
  AST_CFG_KEEP: assert property (byte_done && (is_cfg || is_res) |=> tx_on_ff == $past(tx_on_ff))
    else $error("configuration or reserved command changed the transmitter");
  AST_PARITY: assert property (byte_done && !par_ok |=> parity_err_ff && !cmd_valid_ff)
    else $error("bad parity byte was accepted");
  AST_DIRECT_EXIT: assert property (run_exit |=> state_ff == cmd_link_pkg::ST_IDLE && !tx_on_ff)
    else $error("strobe fall did not leave direct mode");
  AST_DIRECT_MOD: assert property (in_run && !ev.strobe_fall |=> mod_out == $past(ev.data))
    else $error("modulator does not follow data-in in direct mode");
  AST_TX_HOLD: assert property (tx_on_ff && !shutdown && !run_exit |=> tx_on_ff)
    else $error("transmitter dropped without a shutdown");
endmodule // transceiver_command_link

// ===== sim/link_host.sv
// Behavioural host controller that drives the strobe and data-in lines
`timescale 1ns/1ps
module link_host #(
  parameter int STEP_NS = 200
) (
  output logic strobe_out,
  output logic data_out
);
  // Strobe idles low outside frames; every edge outside pulse sits a full step from the last so the filter never merges two
  initial begin
    strobe_out = 1'b0;
    data_out = 1'b0;
  end
  task automatic set_strobe(input logic v);
    strobe_out <= v;
    #(STEP_NS);
  endtask
  task automatic set_data(input logic v);
    data_out <= v;
    #(STEP_NS);
  endtask
  task automatic start_cond();
    set_data(1'b0);
    set_strobe(1'b1);
    set_data(1'b1);
    set_strobe(1'b0);
  endtask
  task automatic send_bit(input logic b);
    set_data(b);
    set_strobe(1'b1);
    set_strobe(1'b0);
  endtask
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i]);
    end
  endtask
  task automatic stop_cond();
    set_data(1'b1);
    set_strobe(1'b1);
    set_data(1'b0);
    set_strobe(1'b0);
  endtask
  // Data pulse under a high strobe; a short width stands for a spike or a bare start and stop
  task automatic pulse(input int width_ns);
    set_data(1'b0);
    set_strobe(1'b1);
    data_out <= 1'b1;
    #(width_ns);
    set_data(1'b0);
    set_strobe(1'b0);
  endtask
endmodule // link_host

// ===== sim/testbench.sv
// Self-checking bench for the serial command link front end
`timescale 1ns/1ps
module testbench;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic strobe_in;
  logic data_in;
  logic demod_in = 1'b0;
  logic data_out, tx_on_out, mod_out, direct_active_out, register_mode_out, depth_full_out, am_demod_out;
  logic high_baud_out, cmd_valid_out, parity_err_out, cfg_read_out, cfg_write_out, power_down_out;
  logic cfg_load_out, payload_valid_out, payload_bit_out, frame_end_out, carrier_shutdown_out;
  logic [2:0] protocol_out;
  int failures = 0;
  int checks = 0;
  // Pulse counts: valid, parity error, read, write, power down, shutdown, frame end
  int got_n[7];
  int exp_n[7];
  logic got_q[$];
  logic exp_q[$];
  logic [31:0] seed = 32'h00010758;
  logic demod_val = 1'b0;
  logic demod_hold = 1'b0;
  logic [31:0] noise = 32'h00010758;
  logic exp_tx = 1'b0;

  always #12.5 ref_clk_in = ~ref_clk_in;
  // Receive data is noise outside the direct test, so a leak onto data_out is caught
  always @(posedge ref_clk_in) begin
    noise <= lfsr(noise);
    demod_in <= demod_hold ? demod_val : noise[0];
  end

  link_host #(.STEP_NS(200)) host (.strobe_out(strobe_in), .data_out(data_in));
  transceiver_command_link dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .strobe_in(strobe_in),
    .data_in(data_in), .demod_in(demod_in), .data_out(data_out), .tx_on_out(tx_on_out), .mod_out(mod_out),
    .direct_active_out(direct_active_out), .register_mode_out(register_mode_out), .protocol_out(protocol_out),
    .depth_full_out(depth_full_out), .am_demod_out(am_demod_out), .high_baud_out(high_baud_out),
    .cmd_valid_out(cmd_valid_out), .parity_err_out(parity_err_out), .cfg_read_out(cfg_read_out),
    .cfg_write_out(cfg_write_out), .power_down_out(power_down_out), .cfg_load_out(cfg_load_out),
    .payload_valid_out(payload_valid_out), .payload_bit_out(payload_bit_out), .frame_end_out(frame_end_out),
    .carrier_shutdown_out(carrier_shutdown_out));

  always @(posedge ref_clk_in) begin
    if (rst_in === 1'b0) begin
      got_n[0] += (cmd_valid_out === 1'b1);
      got_n[1] += (parity_err_out === 1'b1);
      got_n[2] += (cfg_read_out === 1'b1);
      got_n[3] += (cfg_write_out === 1'b1);
      got_n[4] += (power_down_out === 1'b1);
      got_n[5] += (carrier_shutdown_out === 1'b1);
      got_n[6] += (frame_end_out === 1'b1);
      if (payload_valid_out === 1'b1) got_q.push_back(payload_bit_out);
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] with_parity(input logic [6:0] hi);
    return {hi, ^hi};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send_payload(input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      b = seed[0];
      exp_q.push_back(b);
      host.send_bit(b);
    end
  endtask
  // The strobe rise that carries a stop is itself taken as a payload bit, always a one
  task automatic close_frame();
    exp_q.push_back(1'b1);
    exp_n[6]++;
    host.stop_cond();
  endtask
  task automatic end_test(input string name);
    repeat (10) @(posedge ref_clk_in);
    for (int i = 0; i < 7; i++) chk(8'(got_n[i]), 8'(exp_n[i]));
    chk(8'(got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) chk({7'h00, got_q[i]}, {7'h00, exp_q[i]});
    got_q.delete();
    exp_q.delete();
    chk({7'h00, tx_on_out}, {7'h00, exp_tx});
    chk({6'h00, mod_out, data_out}, 8'h00);
    $display("test %s done, checks %0d", name, checks);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run is near 4300 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    stop_test();
  end

  initial begin
    logic [7:0] cmd;
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    host.start_cond();
    host.send_bit(1'b1);
    send_payload(3);
    close_frame();
    exp_n[0]++;
    exp_tx = 1'b1;
    end_test("register_on");
    chk({7'h00, register_mode_out}, 8'h01);
    for (int p = 1; p <= 4; p++) begin
      seed = lfsr(seed);
      cmd = with_parity({1'b0, 3'(p), seed[3:1]});
      host.start_cond();
      host.send_byte(cmd);
      send_payload(2);
      close_frame();
      exp_n[0]++;
      end_test("rf_command");
      chk({1'b0, register_mode_out, protocol_out, depth_full_out, am_demod_out, high_baud_out}, {1'b0, cmd[7:1]});
    end
    for (int k = 0; k < 3; k++) begin
      cmd = (k == 0) ? 8'h71 : (k == 1) ? 8'h7D : 8'h7E;
      host.start_cond();
      host.send_byte(cmd);
      if (k == 1) begin
        send_payload(8);
        close_frame();
      end else begin
        host.stop_cond();
      end
      exp_n[2 + k]++;
      end_test("config_command");
      chk({7'h00, cfg_load_out}, {7'h00, k == 1});
    end
    for (int k = 0; k < 3; k++) begin
      cmd = (k == 0) ? 8'h13 : with_parity({1'b0, (k == 1) ? 3'h5 : 3'h6, 3'h5});
      host.start_cond();
      host.send_byte(cmd);
      host.send_bit(1'b1);
      host.stop_cond();
      if (k == 0) exp_n[1]++;
      end_test("refused_byte");
    end
    host.start_cond();
    host.send_bit(1'b0);
    host.send_bit(1'b1);
    host.send_bit(1'b1);
    cmd = with_parity(7'h16);
    host.start_cond();
    host.send_byte(cmd);
    send_payload(1);
    close_frame();
    exp_n[0]++;
    end_test("restart");
    chk({5'h00, protocol_out}, 8'h02);
    host.pulse(40);
    host.send_bit(1'b1);
    host.stop_cond();
    end_test("glitch");
    host.pulse(150);
    host.pulse(400);
    end_test("short_pulse");
    host.pulse(1600);
    exp_n[5]++;
    exp_tx = 1'b0;
    end_test("shutdown");
    cmd = with_parity(7'h06);
    host.start_cond();
    host.send_byte(cmd);
    host.stop_cond();
    exp_n[0]++;
    exp_tx = 1'b1;
    demod_hold = 1'b1;
    host.set_strobe(1'b1);
    chk({7'h00, direct_active_out}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      demod_val = seed[0];
      host.set_data(seed[1]);
      repeat (4) @(posedge ref_clk_in);
      chk({6'h00, mod_out, data_out}, {6'h00, seed[1], seed[0]});
    end
    demod_hold = 1'b0;
    host.set_data(1'b0);
    host.set_strobe(1'b0);
    exp_tx = 1'b0;
    end_test("direct");
    chk({7'h00, direct_active_out}, 8'h00);
    stop_test();
  end
endmodule // testbench
